/* File: ocss_consts.svh */
// Summary of operation
// - output zero select: 00 general divider A, 01 precision divider C.
// - output one select: 00 general divider B, 01 precision divider C.
// - selects of outputs one and three act only in single-ended pair modes.
// - differential pair zero/one: output one is inverted output zero.
// - output two select: 00 general divider C, 01 precision divider D.
// - output three select: 00 general divider D, 01 precision divider D.
// - differential pair two/three: output three is inverted output two.
// - halt field 00/01 runs; 10 stops output four low at falling edge.
// - halt field 11 stops output four high at rising edge until changed.
// - pair mode: 000 off, 001-011 CMOS, 100 complementary, 101 HCSL, 110 PECL.
`ifndef OCSS_CONSTS_SVH
`define OCSS_CONSTS_SVH

// ***********************************
// register map
// ***********************************
`define OCSS_ADDR_SOURCE_SELECT_LOW 8'hB5
`define OCSS_ADDR_SYNTH_THREE_STOP  8'hB6
`define OCSS_RESET_SOURCE_SELECT    8'h00
`define OCSS_RESET_SYNTH_THREE_STOP 8'h00
`define OCSS_READ_UNMAPPED          8'h00

// ***********************************
// field positions
// ***********************************
`define OCSS_SEL_ZERO_MSB  1
`define OCSS_SEL_ZERO_LSB  0
`define OCSS_SEL_ONE_MSB   3
`define OCSS_SEL_ONE_LSB   2
`define OCSS_SEL_TWO_MSB   5
`define OCSS_SEL_TWO_LSB   4
`define OCSS_SEL_THREE_MSB 7
`define OCSS_SEL_THREE_LSB 6
`define OCSS_HALT_A_MSB    1
`define OCSS_HALT_A_LSB    0

// ***********************************
// codes
// ***********************************
`define OCSS_SEL_GP        2'h0
`define OCSS_SEL_HP        2'h1
`define OCSS_HALT_FALL     2'h2
`define OCSS_HALT_RISE     2'h3
`define OCSS_MODE_OFF      3'h0
`define OCSS_MODE_CMOS_E   3'h1
`define OCSS_MODE_CMOS_O   3'h2
`define OCSS_MODE_CMOS_EO  3'h3
`define OCSS_MODE_COMPL    3'h4
`define OCSS_MODE_HCSL     3'h5
`define OCSS_MODE_PECL     3'h6

`endif

/* File: ocss_output_clock_select.sv */
`timescale 1ns/1ps
`include "ocss_consts.svh"
module ocss_output_clock_select #(
  parameter int SRC_COUNT = 7
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  // register port
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  output logic      [7:0] regRdData,
  // output mode fields from neighbouring register
  input  wire logic [2:0] pairModeLow,
  input  wire logic [2:0] pairModeHigh,
  // synthesizer divider clocks
  input  wire logic       gpSynthADividerA,
  input  wire logic       gpSynthADividerB,
  input  wire logic       gpSynthADividerC,
  input  wire logic       gpSynthADividerD,
  input  wire logic       hpSynthADividerC,
  input  wire logic       hpSynthADividerD,
  input  wire logic       gpSynthBDividerA,
  // output clocks
  output logic            clockOutZero,
  output logic            clockOutOne,
  output logic            clockOutTwo,
  output logic            clockOutThree,
  output logic            clockOutFour
);
  logic [7:0]           outputSourceSelectLow;
  logic [7:0]           synthThreeStopControl;
  logic [7:0]           next_outputSourceSelectLow;
  logic [7:0]           next_synthThreeStopControl;
  logic [7:0]           next_regRdData;
  logic [SRC_COUNT-1:0] srcRaw;
  logic [SRC_COUNT-1:0] srcMeta;
  logic [SRC_COUNT-1:0] srcSync;
  logic [1:0]           gpSynthBDivAHalt;
  ocss_pkg::ocss_halt_e haltState;
  ocss_pkg::ocss_halt_e next_haltState;
  logic                 next_clockOutFour;

  assign srcRaw = {gpSynthBDividerA, hpSynthADividerD, hpSynthADividerC,
                   gpSynthADividerD, gpSynthADividerC, gpSynthADividerB,
                   gpSynthADividerA};

  // ***********************************
  // source synchronisers
  // ***********************************
  for (genvar i = 0; i < SRC_COUNT; i++) begin : g_sync
    always_ff @(posedge sys_clk) begin
      if (!resetn) begin
        srcMeta[i] <= 1'b0;
        srcSync[i] <= 1'b0;
      end else begin
        srcMeta[i] <= srcRaw[i];
        srcSync[i] <= srcMeta[i];
      end
    end
  end

  // ***********************************
  // register port
  // ***********************************
  always_comb begin
    next_outputSourceSelectLow = outputSourceSelectLow;
    next_synthThreeStopControl = synthThreeStopControl;
    next_regRdData             = regRdData;
    if (regWrEn && regAddr == `OCSS_ADDR_SOURCE_SELECT_LOW) begin
      next_outputSourceSelectLow = regWrData;
    end else if (regWrEn && regAddr == `OCSS_ADDR_SYNTH_THREE_STOP) begin
      next_synthThreeStopControl = regWrData;
    end
    if (regRdEn) begin
      if (regAddr == `OCSS_ADDR_SOURCE_SELECT_LOW) begin
        next_regRdData = outputSourceSelectLow;
      end else if (regAddr == `OCSS_ADDR_SYNTH_THREE_STOP) begin
        next_regRdData = synthThreeStopControl;
      end else begin
        next_regRdData = `OCSS_READ_UNMAPPED;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      outputSourceSelectLow <= `OCSS_RESET_SOURCE_SELECT;
      synthThreeStopControl <= `OCSS_RESET_SYNTH_THREE_STOP;
      regRdData             <= `OCSS_READ_UNMAPPED;
    end else begin
      outputSourceSelectLow <= next_outputSourceSelectLow;
      synthThreeStopControl <= next_synthThreeStopControl;
      regRdData             <= next_regRdData;
    end
  end

  // ***********************************
  // outputs zero to three
  // ***********************************
  // pair zero and one
  ocss_pair_mux u_pair_low (
    .sysClk    (sys_clk),
    .resetn    (resetn),
    .selEven   (outputSourceSelectLow[`OCSS_SEL_ZERO_MSB:`OCSS_SEL_ZERO_LSB]),
    .selOdd    (outputSourceSelectLow[`OCSS_SEL_ONE_MSB:`OCSS_SEL_ONE_LSB]),
    .pairMode  (pairModeLow),
    .evenGp    (srcSync[0]),
    .evenHp    (srcSync[4]),
    .oddGp     (srcSync[1]),
    .oddHp     (srcSync[4]),
    .clockEven (clockOutZero),
    .clockOdd  (clockOutOne)
  );

  ocss_pair_mux u_pair_high (
    .sysClk    (sys_clk),
    .resetn    (resetn),
    .selEven   (outputSourceSelectLow[`OCSS_SEL_TWO_MSB:`OCSS_SEL_TWO_LSB]),
    .selOdd    (outputSourceSelectLow[`OCSS_SEL_THREE_MSB:`OCSS_SEL_THREE_LSB]),
    .pairMode  (pairModeHigh),
    .evenGp    (srcSync[2]),
    .evenHp    (srcSync[5]),
    .oddGp     (srcSync[3]),
    .oddHp     (srcSync[5]),
    .clockEven (clockOutTwo),
    .clockOdd  (clockOutThree)
  );

  // ***********************************
  // output four halt control
  // ***********************************
  assign gpSynthBDivAHalt = synthThreeStopControl[`OCSS_HALT_A_MSB:`OCSS_HALT_A_LSB];

  always_comb begin
    next_haltState    = haltState;
    next_clockOutFour = clockOutFour;
    case (haltState)
      ocss_pkg::HALT_RUN: begin
        next_clockOutFour = srcSync[6];
        if (gpSynthBDivAHalt == `OCSS_HALT_FALL && clockOutFour && !srcSync[6]) begin
          next_haltState = ocss_pkg::HALT_LOW;
        end else if (gpSynthBDivAHalt == `OCSS_HALT_RISE && !clockOutFour && srcSync[6]) begin
          next_haltState = ocss_pkg::HALT_HIGH;
        end
      end
      ocss_pkg::HALT_LOW: begin
        next_clockOutFour = 1'b0;
        if (gpSynthBDivAHalt != `OCSS_HALT_FALL && !srcSync[6]) begin
          next_haltState = ocss_pkg::HALT_RUN;
        end
      end
      ocss_pkg::HALT_HIGH: begin
        next_clockOutFour = 1'b1;
        if (gpSynthBDivAHalt != `OCSS_HALT_RISE && srcSync[6]) begin
          next_haltState = ocss_pkg::HALT_RUN;
        end
      end
      default: begin
        next_haltState    = ocss_pkg::HALT_RUN;
        next_clockOutFour = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      haltState    <= ocss_pkg::HALT_RUN;
      clockOutFour <= 1'b0;
    end else begin
      haltState    <= next_haltState;
      clockOutFour <= next_clockOutFour;
    end
  end
endmodule : ocss_output_clock_select

/* File: ocss_output_clock_select_properties.sv */
`timescale 1ns/1ps
module ocss_output_clock_select_properties #(
  parameter int SRC_COUNT = 7
) (
  // clock, reset, register writes
  input wire logic       sys_clk,
  input wire logic       resetn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWrEn,
  // mode fields and sources
  input wire logic [2:0] pairModeLow,
  input wire logic [2:0] pairModeHigh,
  input wire logic       gpSynthADividerA,
  input wire logic       gpSynthADividerB,
  input wire logic       gpSynthADividerD,
  input wire logic       hpSynthADividerC,
  input wire logic       hpSynthADividerD,
  // output clocks
  input wire logic       clockOutZero,
  input wire logic       clockOutOne,
  input wire logic       clockOutTwo,
  input wire logic       clockOutThree,
  input wire logic       clockOutFour
);
  logic [7:0] sel, next_sel;
  logic [1:0] halt, next_halt;
  // shadow copies of the select register and the halt field
  always_comb begin
    next_sel  = !resetn ? 8'h00 : (regWrEn && regAddr == 8'hB5) ? regWrData : sel;
    next_halt = !resetn ? 2'h0 : (regWrEn && regAddr == 8'hB6) ? regWrData[1:0] : halt;
  end
  always_ff @(posedge sys_clk) begin
    sel  <= next_sel;
    halt <= next_halt;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // quiet cycles let config and syncs settle
  sequence calm;
    (!regWrEn && $stable(pairModeLow) && $stable(pairModeHigh)) [*5];
  endsequence
  // select held steady over calm, so the current select names the source
  zero_route_a: assert property (calm ##0 (pairModeLow == 3'h3 && !sel[1]) |->
    clockOutZero == (sel[0] ? $past(hpSynthADividerC, 3) : $past(gpSynthADividerA, 3)))
    else $error("output zero source wrong");
  one_route_a: assert property (calm ##0 (pairModeLow == 3'h3 && !sel[3]) |->
    clockOutOne == (sel[2] ? $past(hpSynthADividerC, 3) : $past(gpSynthADividerB, 3)))
    else $error("output one source wrong");
  three_route_a: assert property (calm ##0 (pairModeHigh == 3'h3 && !sel[7]) |->
    clockOutThree == (sel[6] ? $past(hpSynthADividerD, 3) : $past(gpSynthADividerD, 3)))
    else $error("output three source wrong");
  low_invert_a: assert property (calm ##0 (pairModeLow inside {[4:6]} && !sel[1]) |->
    clockOutOne != clockOutZero) else $error("output one not inverted");
  high_invert_a: assert property (calm ##0 (pairModeHigh inside {[4:6]} && !sel[5]) |->
    clockOutThree != clockOutTwo) else $error("output three not inverted");
  reserved_low_a: assert property (calm ##0 (pairModeLow == 3'h3 && sel[1]) |->
    !clockOutZero) else $error("reserved select drives clock");
  mode_off_a: assert property (calm ##0 pairModeLow == 3'h0 |->
    !clockOutZero && !clockOutOne) else $error("disabled pair active");
  // field already set when the fall was launched
  halt_low_a: assert property ((halt == 2'h2 && $past(halt) == 2'h2 && $fell(clockOutFour)) |=>
    !clockOutFour [*8]) else $error("output four not held low");
endmodule : ocss_output_clock_select_properties
bind ocss_output_clock_select ocss_output_clock_select_properties
  #(.SRC_COUNT(SRC_COUNT)) props_u (
    .sys_clk          (sys_clk),
    .resetn           (resetn),
    .regAddr          (regAddr),
    .regWrData        (regWrData),
    .regWrEn          (regWrEn),
    .pairModeLow      (pairModeLow),
    .pairModeHigh     (pairModeHigh),
    .gpSynthADividerA (gpSynthADividerA),
    .gpSynthADividerB (gpSynthADividerB),
    .gpSynthADividerD (gpSynthADividerD),
    .hpSynthADividerC (hpSynthADividerC),
    .hpSynthADividerD (hpSynthADividerD),
    .clockOutZero     (clockOutZero),
    .clockOutOne      (clockOutOne),
    .clockOutTwo      (clockOutTwo),
    .clockOutThree    (clockOutThree),
    .clockOutFour     (clockOutFour)
  );

/* File: ocss_pair_mux.sv */
`timescale 1ns/1ps
`include "ocss_consts.svh"
module ocss_pair_mux (
  // clock and reset
  input  wire logic       sysClk,
  input  wire logic       resetn,
  // configuration
  input  wire logic [1:0] selEven,
  input  wire logic [1:0] selOdd,
  input  wire logic [2:0] pairMode,
  // synchronised sources
  input  wire logic       evenGp,
  input  wire logic       evenHp,
  input  wire logic       oddGp,
  input  wire logic       oddHp,
  // pair outputs
  output logic            clockEven,
  output logic            clockOdd
);
  logic evenSrc;
  logic oddSrc;
  logic next_clockEven;
  logic next_clockOdd;

  // ***********************************
  // source select and pair mode
  // ***********************************
  always_comb begin
    evenSrc = 1'b0;
    oddSrc  = 1'b0;
    if (selEven == `OCSS_SEL_GP) begin
      evenSrc = evenGp;
    end else if (selEven == `OCSS_SEL_HP) begin
      evenSrc = evenHp;
    end
    if (selOdd == `OCSS_SEL_GP) begin
      oddSrc = oddGp;
    end else if (selOdd == `OCSS_SEL_HP) begin
      oddSrc = oddHp;
    end
    next_clockEven = 1'b0;
    next_clockOdd  = 1'b0;
    case (pairMode)
      `OCSS_MODE_CMOS_E: begin
        next_clockEven = evenSrc;
      end
      `OCSS_MODE_CMOS_O: begin
        next_clockOdd = oddSrc;
      end
      `OCSS_MODE_CMOS_EO: begin
        next_clockEven = evenSrc;
        next_clockOdd  = oddSrc;
      end
      `OCSS_MODE_COMPL, `OCSS_MODE_HCSL, `OCSS_MODE_PECL: begin
        next_clockEven = evenSrc;
        next_clockOdd  = ~evenSrc;
      end
      default: begin
        next_clockEven = 1'b0;
        next_clockOdd  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sysClk) begin
    if (!resetn) begin
      clockEven <= 1'b0;
      clockOdd  <= 1'b0;
    end else begin
      clockEven <= next_clockEven;
      clockOdd  <= next_clockOdd;
    end
  end
endmodule : ocss_pair_mux

/* File: ocss_pkg.sv */
package ocss_pkg;
  typedef enum logic [2:0] {
    HALT_RUN  = 3'h1,
    HALT_LOW  = 3'h2,
    HALT_HIGH = 3'h4
  } ocss_halt_e;
endpackage : ocss_pkg

/* File: ocss_src_model.sv */
`timescale 1ns/1ps
module ocss_src_model #(
  parameter int BASE_HALF = 123
) (
  // free-running divider clocks, odd half periods
  output logic [6:0] srcClk
);
  for (genvar i = 0; i < 7; i++) begin : g_src
    initial begin
      srcClk[i] = 1'b0;
      // half-step offset keeps source edges off the sampling edge
      #0.5;
      forever #(BASE_HALF + 58 * i) srcClk[i] = ~srcClk[i];
    end
  end
endmodule : ocss_src_model

/* File: test_output_clock_select_and_stop.sv */
`timescale 1ns/1ps
module test_output_clock_select_and_stop;
  logic       sys_clk, resetn, regWrEn, regRdEn;
  logic [7:0] regAddr, regWrData, regRdData;
  logic [2:0] pairModeLow, pairModeHigh;
  logic [6:0] src, h0, h1, h2;
  logic       clockOutZero, clockOutOne, clockOutTwo, clockOutThree, clockOutFour;
  wire logic  gpSynthADividerA, gpSynthADividerB, gpSynthADividerC, gpSynthADividerD;
  wire logic  hpSynthADividerC, hpSynthADividerD, gpSynthBDividerA;
  int         numErrors = 0;
  int         checkCount = 0;
  logic [2:0] modes [4] = '{3'h0, 3'h1, 3'h2, 3'h7};
  assign {gpSynthBDividerA, hpSynthADividerD, hpSynthADividerC, gpSynthADividerD,
          gpSynthADividerC, gpSynthADividerB, gpSynthADividerA} = src;
  ocss_src_model src_u (.srcClk(src));
  ocss_output_clock_select dut_u (
    .sys_clk          (sys_clk),
    .resetn           (resetn),
    .regAddr          (regAddr),
    .regWrData        (regWrData),
    .regWrEn          (regWrEn),
    .regRdEn          (regRdEn),
    .regRdData        (regRdData),
    .pairModeLow      (pairModeLow),
    .pairModeHigh     (pairModeHigh),
    .gpSynthADividerA (gpSynthADividerA),
    .gpSynthADividerB (gpSynthADividerB),
    .gpSynthADividerC (gpSynthADividerC),
    .gpSynthADividerD (gpSynthADividerD),
    .hpSynthADividerC (hpSynthADividerC),
    .hpSynthADividerD (hpSynthADividerD),
    .gpSynthBDividerA (gpSynthBDividerA),
    .clockOutZero     (clockOutZero),
    .clockOutOne      (clockOutOne),
    .clockOutTwo      (clockOutTwo),
    .clockOutThree    (clockOutThree),
    .clockOutFour     (clockOutFour)
  );
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // sources as seen by the output flops
  always @(posedge sys_clk) {h2, h1, h0} <= {h1, h0, src};
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checkCount++;
    if (got !== exp) begin
      numErrors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(posedge sys_clk);
    {regAddr, regWrData, regWrEn, regRdEn} <= {a, d, w, !w};
    @(posedge sys_clk);
    {regWrEn, regRdEn} <= 2'b00;
    @(posedge sys_clk);
    #1;
    if (!w) chk("regRdData", d, regRdData);
  endtask : acc
  function automatic logic pick(input logic [1:0] c, input int g, input int p);
    return c == 2'h0 ? h2[g] : c == 2'h1 ? h2[p] : 1'b0;
  endfunction : pick
  function automatic logic [3:0] exp4(input logic [7:0] s, input logic [2:0] m);
    logic [3:0] r;
    r = {pick(s[7:6], 3, 5), pick(s[5:4], 2, 5), pick(s[3:2], 1, 4), pick(s[1:0], 0, 4)};
    if (m == 3'h1) r = r & 4'h5;
    if (m == 3'h2) r = r & 4'hA;
    if (m == 3'h0 || m == 3'h7) r = 4'h0;
    if (m inside {[4:6]}) r = {~r[2], r[2], ~r[0], r[0]};
    return r;
  endfunction : exp4
  task automatic scan(input logic [7:0] s, input logic [2:0] m);
    @(posedge sys_clk);
    {pairModeLow, pairModeHigh} <= {m, m};
    acc(8'hB5, s, 1'b1);
    repeat (5) @(posedge sys_clk);
    repeat (10) begin
      @(posedge sys_clk);
      #1;
      chk("clockOut", 8'(exp4(s, m)), {4'h0, clockOutThree, clockOutTwo, clockOutOne, clockOutZero});
    end
  endtask : scan
  task automatic test_regs;
    acc(8'hB5, 8'h00, 1'b0);
    acc(8'hB6, 8'h00, 1'b0);
    acc(8'hB6, 8'h5A, 1'b1);
    acc(8'hB6, 8'h5A, 1'b0);
    acc(8'h00, 8'hFF, 1'b1);
    acc(8'h00, 8'h00, 1'b0);
    acc(8'hB5, 8'h00, 1'b0);
  endtask : test_regs
  task automatic test_mux;
    for (int c = 0; c < 4; c++) scan({4{2'(c)}}, 3'h3);
  endtask : test_mux
  task automatic test_pairs;
    for (int m = 4; m < 7; m++) scan(8'hDD, 3'(m));
    foreach (modes[i]) scan(8'h00, modes[i]);
  endtask : test_pairs
  task automatic hold(input logic lvl, input logic fixed);
    repeat (30) @(posedge sys_clk);
    repeat (16) begin
      @(posedge sys_clk);
      #1;
      chk("clockOutFour", {7'h0, fixed ? lvl : h2[6]}, {7'h0, clockOutFour});
    end
  endtask : hold
  task automatic test_halt;
    acc(8'hB6, 8'h02, 1'b1);
    hold(1'b0, 1'b1);
    acc(8'hB6, 8'h03, 1'b1);
    hold(1'b1, 1'b1);
    acc(8'hB6, 8'h00, 1'b1);
    hold(1'b0, 1'b0);
  endtask : test_halt
  task automatic tallyAndFinish;
    if (numErrors == 0 && checkCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tallyAndFinish
  initial begin
    {resetn, regWrEn, regRdEn, regAddr, regWrData} = '0;
    {pairModeLow, pairModeHigh} = '0;
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    test_regs();
    test_mux();
    test_pairs();
    test_halt();
    tallyAndFinish();
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    numErrors++;
    tallyAndFinish();
  end
endmodule : test_output_clock_select_and_stop
